// ### logic/hcmd_defines.svh
`ifndef HCMD_DEFINES_SVH
`define HCMD_DEFINES_SVH

// ****************************************
// function codes
// ****************************************
`define HCMD_NOP          8'h00
`define HCMD_MEM_WR       8'h01
`define HCMD_MEM_RD       8'h02
`define HCMD_CKSUM_CALC   8'h03
`define HCMD_CKSUM_SEND   8'h04
`define HCMD_CTL_FIRST    8'h20
`define HCMD_CTL_NEXT     8'h21
`define HCMD_CTL_FLAG     8'h22
`define HCMD_PROMPT       8'h23
`define HCMD_SHUF_FIRST   8'h30
`define HCMD_SHUF_NEXT    8'h31
`define HCMD_SHUF_FLAG    8'h32
`define HCMD_SERVO_LD1    8'h3D
`define HCMD_SERVO_LD2    8'h3E
`define HCMD_TIME_REF     8'h41
`define HCMD_OBS_CTRL     8'h50
`define HCMD_TEST_PAT     8'h72
`define HCMD_TRC_WR       8'h80
`define HCMD_TRC_RD       8'h81
`define HCMD_TRC_RST      8'h82

// ****************************************
// lengths in bytes and counts of next commands
// ****************************************
`define HCMD_ADDR_CNT_LEN 16'h0006
`define HCMD_CKSUM_LEN    16'h0002
`define HCMD_FLAG_LEN     16'h0001
`define HCMD_PROMPT_LEN   16'h0004
`define HCMD_CTL_PART     16'h0606
`define HCMD_CTL_NEXT_N   4'h2
`define HCMD_SHUF_PART    16'h0739
`define HCMD_SHUF_NEXT_N  4'h5
`define HCMD_SERVO_LEN    16'h0500
`define HCMD_TIME_LEN     16'h0009
`define HCMD_OBS_LEN      16'h0002
`define HCMD_TEST_PAT_LEN 16'h0408
`define HCMD_TRC_WR_HDR   16'h0003
`define HCMD_TRC_RD_HDR   16'h0005
`define HCMD_STAT60_LEN   16'h0010
`define HCMD_STAT62_LEN   16'h0484

// ****************************************
// target field width in bits
// ****************************************
`define HCMD_TARGET_W     6

`endif

// ### logic/hcmd_pkg.sv
package hcmd_pkg;
    typedef logic [7:0] hcmd_byte_t;
    typedef logic [15:0] hcmd_len_t;
    typedef enum logic [1:0] {
        HCMD_CNT_NONE,
        HCMD_CNT_AT_4,
        HCMD_CNT_AT_1
    } hcmd_cnt_e;
    typedef enum logic [1:0] {
        HCMD_RSP_FIXED,
        HCMD_RSP_FROM_CNT,
        HCMD_RSP_FROM_3
    } hcmd_rsp_e;
endpackage : hcmd_pkg

// ### logic/hcmd_dec_if.sv
interface hcmd_dec_if;
    import hcmd_pkg::*;
    hcmd_byte_t code;
    logic       known;
    hcmd_len_t  hdr_len;
    hcmd_cnt_e  cnt_kind;
    hcmd_rsp_e  rsp_kind;
    hcmd_len_t  rsp_len;
    modport user (output code, input known, hdr_len, cnt_kind, rsp_kind, rsp_len);
    modport dec  (input code, output known, hdr_len, cnt_kind, rsp_kind, rsp_len);
endinterface : hcmd_dec_if

// ### logic/hcmd_decoder.sv
`include "hcmd_defines.svh"

module hcmd_decoder (
    hcmd_dec_if.dec d
);
    import hcmd_pkg::*;

    always_comb begin
        d.known    = 1'b1;
        d.hdr_len  = 16'h0000;
        d.cnt_kind = HCMD_CNT_NONE;
        d.rsp_kind = HCMD_RSP_FIXED;
        d.rsp_len  = 16'h0000;
        case (d.code)
            `HCMD_NOP, 8'h28, 8'h29, 8'h35, 8'h3B, 8'h3F, 8'h40, 8'h70, 8'h71, 8'h75,
            `HCMD_TRC_RST: d.hdr_len = 16'h0001;
            `HCMD_MEM_WR: begin
                d.hdr_len  = `HCMD_ADDR_CNT_LEN;
                d.cnt_kind = HCMD_CNT_AT_4;
            end
            `HCMD_MEM_RD: begin
                d.hdr_len  = `HCMD_ADDR_CNT_LEN;
                d.rsp_kind = HCMD_RSP_FROM_CNT;
            end
            `HCMD_CKSUM_CALC: begin
                d.hdr_len = `HCMD_ADDR_CNT_LEN;
                d.rsp_len = `HCMD_CKSUM_LEN;
            end
            `HCMD_CKSUM_SEND: d.rsp_len = `HCMD_CKSUM_LEN;
            `HCMD_CTL_FIRST, `HCMD_CTL_NEXT: d.hdr_len = `HCMD_CTL_PART;
            `HCMD_SHUF_FIRST, `HCMD_SHUF_NEXT: d.hdr_len = `HCMD_SHUF_PART;
            `HCMD_CTL_FLAG, `HCMD_SHUF_FLAG: d.rsp_len = `HCMD_FLAG_LEN;
            `HCMD_PROMPT, 8'h33, 8'h36, 8'h37: d.hdr_len = `HCMD_PROMPT_LEN;
            8'h34, 8'h3C: d.hdr_len = 16'h0002;
            8'h38: d.hdr_len = 16'h0024;
            8'h39, 8'h3A: d.hdr_len = 16'h0003;
            `HCMD_SERVO_LD1, `HCMD_SERVO_LD2: d.hdr_len = `HCMD_SERVO_LEN;
            `HCMD_TIME_REF: d.hdr_len = `HCMD_TIME_LEN;
            8'h42: d.hdr_len = 16'h0010;
            `HCMD_OBS_CTRL: d.hdr_len = `HCMD_OBS_LEN;
            8'h60: d.rsp_len = `HCMD_STAT60_LEN;
            8'h61, 8'h69: d.rsp_len = 16'h0007;
            8'h62: d.rsp_len = `HCMD_STAT62_LEN;
            8'h63: d.rsp_len = 16'h0018;
            8'h64: d.rsp_len = 16'h001C;
            8'h65: d.rsp_len = 16'h0038;
            8'h66: d.rsp_len = 16'h0006;
            8'h67: d.rsp_len = 16'h001E;
            8'h68: d.rsp_len = 16'h0048;
            `HCMD_TEST_PAT: d.hdr_len = `HCMD_TEST_PAT_LEN;
            8'h73, 8'h74: d.hdr_len = 16'h0000;
            `HCMD_TRC_WR: begin
                d.hdr_len  = `HCMD_TRC_WR_HDR;
                d.cnt_kind = HCMD_CNT_AT_1;
            end
            `HCMD_TRC_RD: begin
                d.hdr_len  = `HCMD_TRC_RD_HDR;
                d.cnt_kind = HCMD_CNT_AT_1;
                d.rsp_kind = HCMD_RSP_FROM_3;
            end
            default: d.known = 1'b0;
        endcase
    end
endmodule : hcmd_decoder

// ### logic/hcmd_host.sv
// Overview of operation
// - host alone starts every bus transfer; the card never initiates.
// - codes and parameter values are hex; byte counts decimal.
// - code 00 sends one meaningless parameter byte.
// - 01 writes addr, count, data; 02 reads addr, count, returns data.
// - control image: one 20 then two 21 of 1542 bytes; 22 flag.
// - prompt 23 carries exactly four parameter bytes.
// - shuffler image: one 30 then five 31 of 1849; 32 flag.
// - servo table codes 3D and 3E carry 1280 bytes each.
// - time reference 41 selector 00 or 01 then date/time bytes.
// - observation control 50 carries exactly two parameter bytes.
// - 80 writes counted message, 81 reads with length, 82 resets.
// - host sends end-observation at full speed before the drive stops; this module sends 50 only when the user issues it.
`include "hcmd_defines.svh"

module hcmd_host (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    // user command port
    input  wire logic                      cmd_valid,
    input  wire hcmd_pkg::hcmd_byte_t      cmd_code,
    input  wire logic [`HCMD_TARGET_W-1:0] cmd_target,
    output logic                           cmd_ready,
    output logic                           cmd_done,
    output logic                           cmd_refused,
    // user parameter bytes
    input  wire logic                      tx_valid,
    input  wire hcmd_pkg::hcmd_byte_t      tx_data,
    output logic                           tx_ready,
    // user response bytes
    output logic                           rx_valid,
    output hcmd_pkg::hcmd_byte_t           rx_data,
    // status
    output logic                           obs_active,
    // control bus
    output logic [`HCMD_TARGET_W-1:0]      bus_target,
    output logic                           bus_wr_stb,
    output logic                           bus_rd_stb,
    input  wire logic                      bus_ack,
    input  wire hcmd_pkg::hcmd_byte_t      bus_data_in,
    output hcmd_pkg::hcmd_byte_t           bus_data_out,
    output logic                           bus_data_oe
);
    import hcmd_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ****************************************
    // code table
    // ****************************************
    hcmd_dec_if dif ();
    hcmd_decoder u_dec (
        .d (dif.dec)
    );

    typedef enum logic [2:0] {
        HCMD_IDLE,
        HCMD_SEND_CODE,
        HCMD_SEND_PARAM,
        HCMD_RECV,
        HCMD_DONE
    } hcmd_state_e;

    hcmd_state_e state, next_state;
    hcmd_byte_t  code, next_code;
    logic [`HCMD_TARGET_W-1:0] target, next_target;
    hcmd_len_t   idx, next_idx;
    hcmd_len_t   tot, next_tot;
    hcmd_len_t   cnt, next_cnt;
    hcmd_len_t   rsp, next_rsp;
    hcmd_byte_t  data_out, next_data_out;
    logic        wr_stb, next_wr_stb;
    logic        rd_stb, next_rd_stb;
    hcmd_byte_t  rx_d, next_rx_d;
    logic        rx_v, next_rx_v;
    logic        done, next_done;
    logic        refused, next_refused;
    logic [3:0]  ctl_left, next_ctl_left;
    logic [3:0]  shuf_left, next_shuf_left;
    logic        obs, next_obs;
    logic        onehot;
    logic        seq_ok;

    assign dif.code = cmd_code;

    // ****************************************
    // acceptance checks
    // ****************************************
    always_comb begin
        onehot = (cmd_target != '0) && ((cmd_target & (cmd_target - 1'b1)) == '0);
        case (cmd_code)
            `HCMD_CTL_NEXT: seq_ok = (ctl_left != 4'h0);
            `HCMD_SHUF_NEXT: seq_ok = (shuf_left != 4'h0);
            default: seq_ok = 1'b1;
        endcase
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always_comb begin
        next_state     = state;
        next_code      = code;
        next_target    = target;
        next_idx       = idx;
        next_tot       = tot;
        next_cnt       = cnt;
        next_rsp       = rsp;
        next_data_out  = data_out;
        next_wr_stb    = wr_stb;
        next_rd_stb    = rd_stb;
        next_rx_d      = rx_d;
        next_rx_v      = 1'b0;
        next_done      = 1'b0;
        next_refused   = 1'b0;
        next_ctl_left  = ctl_left;
        next_shuf_left = shuf_left;
        next_obs       = obs;
        case (state)
            HCMD_IDLE: begin
                if (cmd_valid) begin
                    // undefined codes never reach the card, which would ignore them anyway
                    if (!dif.known || !onehot || !seq_ok) begin
                        next_refused = 1'b1;
                    end else begin
                        next_code     = cmd_code;
                        next_target   = cmd_target;
                        next_tot      = dif.hdr_len;
                        next_rsp      = dif.rsp_len;
                        next_idx      = 16'h0000;
                        next_cnt      = 16'h0000;
                        next_data_out = cmd_code;
                        next_wr_stb   = 1'b1;
                        next_state    = HCMD_SEND_CODE;
                    end
                end
            end
            HCMD_SEND_CODE: begin
                if (bus_ack) begin
                    next_wr_stb = 1'b0;
                    if (tot != 16'h0000) begin
                        next_state = HCMD_SEND_PARAM;
                    end else if (rsp != 16'h0000) begin
                        next_rd_stb = 1'b1;
                        next_state  = HCMD_RECV;
                    end else begin
                        next_state = HCMD_DONE;
                    end
                end
            end
            HCMD_SEND_PARAM: begin
                if (!wr_stb && tx_valid) begin
                    next_data_out = tx_data;
                    next_wr_stb   = 1'b1;
                    // counts travel most significant byte first
                    case (dif.cnt_kind)
                        default: ;
                    endcase
                    if ((code == `HCMD_MEM_WR || code == `HCMD_MEM_RD) && idx == 16'h0004) begin
                        next_cnt = {tx_data, cnt[7:0]};
                    end else if ((code == `HCMD_MEM_WR || code == `HCMD_MEM_RD) && idx == 16'h0005) begin
                        next_cnt = {cnt[15:8], tx_data};
                        if (code == `HCMD_MEM_WR) begin
                            next_tot = tot + {cnt[15:8], tx_data};
                        end else begin
                            next_rsp = {cnt[15:8], tx_data};
                        end
                    end else if ((code == `HCMD_TRC_WR || code == `HCMD_TRC_RD) && idx == 16'h0001) begin
                        next_cnt = {tx_data, cnt[7:0]};
                    end else if ((code == `HCMD_TRC_WR || code == `HCMD_TRC_RD) && idx == 16'h0002) begin
                        next_cnt = {cnt[15:8], tx_data};
                        next_tot = tot + {cnt[15:8], tx_data};
                    end else if (code == `HCMD_TRC_RD && idx == 16'h0003) begin
                        next_rsp = {tx_data, 8'h00};
                    end else if (code == `HCMD_TRC_RD && idx == 16'h0004) begin
                        next_rsp = {rsp[15:8], tx_data};
                    end else if (code == `HCMD_OBS_CTRL && idx == 16'h0000) begin
                        next_obs = (tx_data != 8'h00);
                    end
                end else if (wr_stb && bus_ack) begin
                    next_wr_stb = 1'b0;
                    next_idx    = idx + 16'h0001;
                    if (idx + 16'h0001 == tot) begin
                        if (rsp != 16'h0000) begin
                            next_rd_stb = 1'b1;
                            next_idx    = 16'h0000;
                            next_state  = HCMD_RECV;
                        end else begin
                            next_state = HCMD_DONE;
                        end
                    end
                end
            end
            HCMD_RECV: begin
                if (rd_stb && bus_ack) begin
                    next_rd_stb = 1'b0;
                    next_rx_d   = bus_data_in;
                    next_rx_v   = 1'b1;
                    next_idx    = idx + 16'h0001;
                    if (idx + 16'h0001 == rsp) begin
                        next_state = HCMD_DONE;
                    end
                end else if (!rd_stb) begin
                    next_rd_stb = 1'b1;
                end
            end
            HCMD_DONE: begin
                next_done = 1'b1;
                case (code)
                    `HCMD_CTL_FIRST: next_ctl_left = `HCMD_CTL_NEXT_N;
                    `HCMD_CTL_NEXT: next_ctl_left = ctl_left - 4'h1;
                    `HCMD_SHUF_FIRST: next_shuf_left = `HCMD_SHUF_NEXT_N;
                    `HCMD_SHUF_NEXT: next_shuf_left = shuf_left - 4'h1;
                    default: ;
                endcase
                // memory, control and shuffler loads (01, 20, 30) drop the card out of observing, so the host view follows
                if (code == `HCMD_MEM_WR || code == `HCMD_SHUF_FIRST || code == `HCMD_CTL_FIRST) begin
                    next_obs = 1'b0;
                end
                next_state = HCMD_IDLE;
            end
            default: next_state = HCMD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state     <= HCMD_IDLE;
            code      <= 8'h00;
            target    <= '0;
            idx       <= 16'h0000;
            tot       <= 16'h0000;
            cnt       <= 16'h0000;
            rsp       <= 16'h0000;
            data_out  <= 8'h00;
            wr_stb    <= 1'b0;
            rd_stb    <= 1'b0;
            rx_d      <= 8'h00;
            rx_v      <= 1'b0;
            done      <= 1'b0;
            refused   <= 1'b0;
            ctl_left  <= 4'h0;
            shuf_left <= 4'h0;
            obs       <= 1'b0;
        end else begin
            state     <= next_state;
            code      <= next_code;
            target    <= next_target;
            idx       <= next_idx;
            tot       <= next_tot;
            cnt       <= next_cnt;
            rsp       <= next_rsp;
            data_out  <= next_data_out;
            wr_stb    <= next_wr_stb;
            rd_stb    <= next_rd_stb;
            rx_d      <= next_rx_d;
            rx_v      <= next_rx_v;
            done      <= next_done;
            refused   <= next_refused;
            ctl_left  <= next_ctl_left;
            shuf_left <= next_shuf_left;
            obs       <= next_obs;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cmd_ready    = (state == HCMD_IDLE);
    assign cmd_done     = done;
    assign cmd_refused  = refused;
    assign tx_ready     = (state == HCMD_SEND_PARAM) && !wr_stb;
    assign rx_valid     = rx_v;
    assign rx_data      = rx_d;
    assign obs_active   = obs;
    assign bus_target   = target;
    assign bus_wr_stb   = wr_stb;
    assign bus_rd_stb   = rd_stb;
    assign bus_data_out = data_out;
    assign bus_data_oe  = wr_stb;
endmodule : hcmd_host

// ### test/hcmd_host_sva.sv
`include "hcmd_defines.svh"

module hcmd_host_sva (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      rstn,
    // command side
    input wire logic                      cmd_valid,
    input wire hcmd_pkg::hcmd_byte_t      cmd_code,
    input wire logic [`HCMD_TARGET_W-1:0] cmd_target,
    input wire logic                      cmd_ready,
    input wire logic                      cmd_refused,
    input wire logic                      rx_valid,
    input wire hcmd_pkg::hcmd_byte_t      rx_data,
    // control bus
    input wire logic [`HCMD_TARGET_W-1:0] bus_target,
    input wire logic                      bus_wr_stb,
    input wire logic                      bus_rd_stb,
    input wire logic                      bus_ack,
    input wire hcmd_pkg::hcmd_byte_t      bus_data_in,
    input wire hcmd_pkg::hcmd_byte_t      bus_data_out,
    input wire logic                      bus_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import hcmd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ****************************************
    // bus handshake
    // ****************************************
    property p_idle_quiet; cmd_ready |-> !bus_wr_stb && !bus_rd_stb; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle");
    property p_wr_hold; bus_wr_stb && !bus_ack |=> bus_wr_stb && $stable(bus_data_out) && $stable(bus_target); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write byte not held");
    property p_rd_hold; bus_rd_stb && !bus_ack |=> bus_rd_stb && $stable(bus_target); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read strobe not held");
    property p_wr_drop; bus_wr_stb && bus_ack |=> !bus_wr_stb; endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("write strobe kept after ack");
    property p_oe; bus_data_oe == bus_wr_stb; endproperty
    a_oe: assert property (p_oe) else $error("drive enable differs from write strobe");
    property p_onehot; (bus_wr_stb || bus_rd_stb) |-> $onehot(bus_target); endproperty
    a_onehot: assert property (p_onehot) else $error("bus target not one-hot");
    // ****************************************
    // command and response
    // ****************************************
    property p_code_first; $rose(bus_wr_stb) && $past(cmd_ready) |-> bus_data_out == $past(cmd_code); endproperty
    a_code_first: assert property (p_code_first) else $error("first byte is not the code");
    property p_rx_data; bus_rd_stb && bus_ack |=> rx_valid && rx_data == $past(bus_data_in); endproperty
    a_rx_data: assert property (p_rx_data) else $error("response byte lost");
    property p_bad_target; cmd_valid && cmd_ready && !$onehot(cmd_target) |-> ##[1:2] cmd_refused; endproperty
    a_bad_target: assert property (p_bad_target) else $error("bad target not refused");
    property p_unknown; cmd_valid && cmd_ready && cmd_code == 8'hFF |=> (!bus_wr_stb && !bus_rd_stb) [*3]; endproperty
    a_unknown: assert property (p_unknown) else $error("unknown code reached the bus");
endmodule : hcmd_host_sva

bind hcmd_host hcmd_host_sva hcmd_host_sva_i (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_target(cmd_target), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
    .rx_valid(rx_valid), .rx_data(rx_data), .bus_target(bus_target), .bus_wr_stb(bus_wr_stb),
    .bus_rd_stb(bus_rd_stb), .bus_ack(bus_ack), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe));

// ### test/hcmd_dev_model.sv
module hcmd_dev_model #(
    parameter logic [5:0] MY_TARGET = 6'h04
) (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 rstn,
    // control bus
    input wire logic [5:0]           bus_target,
    input wire logic                 bus_wr_stb,
    input wire logic                 bus_rd_stb,
    input wire hcmd_pkg::hcmd_byte_t bus_data_out,
    output logic                     bus_ack,
    output hcmd_pkg::hcmd_byte_t     bus_data_in,
    // answer speed
    input wire logic [3:0]           delay
);
    timeunit 1ns;
    timeprecision 1ps;
    import hcmd_pkg::*;
    hcmd_byte_t wrq[$];
    hcmd_byte_t rd_val;
    logic [3:0] wait_cnt;
    // data line toggles whenever no byte is offered, so a stale capture shows up
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_ack     <= 1'b0;
            bus_data_in <= 8'h00;
            rd_val      <= 8'h00;
            wait_cnt    <= 4'h0;
        end else begin
            bus_data_in <= ~bus_data_in;
            if (bus_ack) begin
                bus_ack  <= 1'b0;
                wait_cnt <= 4'h0;
            end else if ((bus_wr_stb || bus_rd_stb) && bus_target == MY_TARGET) begin
                if (wait_cnt < delay) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end else begin
                    bus_ack <= 1'b1;
                    if (bus_wr_stb) begin
                        wrq.push_back(bus_data_out);
                    end else begin
                        bus_data_in <= rd_val;
                        rd_val      <= rd_val + 8'h01;
                    end
                end
            end
        end
    end
endmodule : hcmd_dev_model

// ### test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hcmd_pkg::*;
    typedef struct { hcmd_byte_t code; hcmd_byte_t p0; int np; int nr; } hcmd_row_s;
    localparam logic [5:0] TGT   = 6'h04;
    localparam int         LIMIT = 100000;
    logic       core_clk = 0, rstn = 0, cmd_valid = 0, tx_valid = 0;
    hcmd_byte_t cmd_code = 0, tx_data = 0, rx_data, bus_data_in, bus_data_out, rd_exp = 0;
    logic [5:0] cmd_target = TGT, bus_target;
    logic       cmd_ready, cmd_done, cmd_refused, tx_ready, rx_valid, obs_active;
    logic       bus_wr_stb, bus_rd_stb, bus_ack, bus_data_oe;
    logic [3:0] dev_delay = 0;
    int         failures = 0, cmp_count = 0, done_cnt = 0, ref_cnt = 0, cyc = 0;
    hcmd_byte_t rxq[$];
    hcmd_row_s  rows[31] = '{
        '{8'h00, 8'h5A, 1, 0}, '{8'h01, 8'h00, 9, 0}, '{8'h02, 8'h00, 6, 3},
        '{8'h03, 8'h00, 6, 2}, '{8'h04, 8'h00, 0, 2},
        '{8'h20, 8'h00, 1542, 0}, '{8'h21, 8'h00, 1542, 0}, '{8'h21, 8'h00, 1542, 0}, '{8'h22, 8'h00, 0, 1},
        '{8'h23, 8'h30, 4, 0}, '{8'h30, 8'h00, 1849, 0}, '{8'h31, 8'h00, 1849, 0},
        '{8'h31, 8'h00, 1849, 0}, '{8'h31, 8'h00, 1849, 0}, '{8'h31, 8'h00, 1849, 0},
        '{8'h31, 8'h00, 1849, 0}, '{8'h32, 8'h00, 0, 1},
        '{8'h3D, 8'h00, 1280, 0}, '{8'h3E, 8'h00, 1280, 0},
        '{8'h41, 8'h00, 9, 0}, '{8'h41, 8'h01, 9, 0}, '{8'h50, 8'h01, 2, 0},
        '{8'h60, 8'h00, 0, 16}, '{8'h62, 8'h00, 0, 1156}, '{8'h72, 8'h00, 1032, 0},
        '{8'h68, 8'h00, 0, 72}, '{8'h69, 8'h00, 0, 7}, '{8'h73, 8'h00, 0, 0},
        '{8'h80, 8'h00, 5, 0}, '{8'h81, 8'h00, 5, 4}, '{8'h82, 8'h00, 1, 0}};

    hcmd_host hcmd_host_i (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_target(cmd_target), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .obs_active(obs_active), .bus_target(bus_target), .bus_wr_stb(bus_wr_stb), .bus_rd_stb(bus_rd_stb),
        .bus_ack(bus_ack), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
    hcmd_dev_model #(.MY_TARGET(TGT)) hcmd_dev_model_i (.core_clk(core_clk), .rstn(rstn),
        .bus_target(bus_target), .bus_wr_stb(bus_wr_stb), .bus_rd_stb(bus_rd_stb),
        .bus_data_out(bus_data_out), .bus_ack(bus_ack), .bus_data_in(bus_data_in), .delay(dev_delay));

    always #25 core_clk = ~core_clk;

    // pulses are counted on the edge that ends them, before the registers move
    always @(posedge core_clk) begin
        cyc++;
        if (cmd_done === 1'b1) done_cnt++;
        if (cmd_refused === 1'b1) ref_cnt++;
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (cyc == LIMIT) begin
            failures++;
            close_out();
        end
    end

    // parameter byte i; count fields carry small values so long commands stay short
    function automatic hcmd_byte_t pb(input hcmd_byte_t code, input int i, input hcmd_byte_t p0);
        if (i == 0) return p0;
        if ((code == 8'h01 || code == 8'h02) && (i == 4 || i == 5)) return (i == 5) ? 8'h03 : 8'h00;
        if ((code == 8'h80 || code == 8'h81) && (i == 1 || i == 2)) return (code == 8'h80 && i == 2) ? 8'h02 : 8'h00;
        if (code == 8'h81 && (i == 3 || i == 4)) return (i == 4) ? 8'h04 : 8'h00;
        return 8'(i);
    endfunction : pb

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic send(input hcmd_byte_t b);
        tx_valid = 1'b1;
        tx_data  = b;
        while (tx_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
    endtask : send

    task automatic run(input hcmd_byte_t code, p0, input int np, nr, input logic [5:0] tgt, input logic refuse);
        int d0;
        int r0;
        rxq.delete();
        hcmd_dev_model_i.wrq.delete();
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        d0         = done_cnt;
        r0         = ref_cnt;
        cmd_valid  = 1'b1;
        cmd_code   = code;
        cmd_target = tgt;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (int i = 0; i < np; i++) send(pb(code, i, p0));
        tx_valid = 1'b0;
        while (done_cnt == d0 && ref_cnt == r0) @(negedge core_clk);
        chk("refused", 16'(refuse), 16'(ref_cnt != r0));
        chk("rx count", 16'(nr), 16'(rxq.size()));
        chk("bus bytes", refuse ? 16'h0000 : 16'(np + 1), 16'(hcmd_dev_model_i.wrq.size()));
        foreach (hcmd_dev_model_i.wrq[i])
            chk("bus byte", (i == 0) ? code : pb(code, i - 1, p0), hcmd_dev_model_i.wrq[i]);
        foreach (rxq[i]) begin
            chk("rx byte", rd_exp, rxq[i]);
            rd_exp++;
        end
    endtask : run

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge core_clk);
        chk("ready in reset", 16'h0001, 16'(cmd_ready));
        chk("strobes in reset", 16'h0000, 16'({bus_wr_stb, bus_rd_stb, obs_active}));
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        foreach (rows[k]) run(rows[k].code, rows[k].p0, rows[k].np, rows[k].nr, TGT, 1'b0);
        // a slow device must not change what is returned
        dev_delay = 4'h3;
        run(8'h04, 8'h00, 0, 2, TGT, 1'b0);
        dev_delay = 4'h0;
        run(8'h21, 8'h00, 0, 0, TGT, 1'b1);
        run(8'h31, 8'h00, 0, 0, TGT, 1'b1);
        run(8'hFF, 8'h00, 0, 0, TGT, 1'b1);
        run(8'h00, 8'h00, 0, 0, 6'h03, 1'b1);
        run(8'h50, 8'h01, 2, 0, TGT, 1'b0);
        chk("observing", 16'h0001, 16'(obs_active));
        run(8'h01, 8'h00, 9, 0, TGT, 1'b0);
        chk("observing after load", 16'h0000, 16'(obs_active));
        run(8'h50, 8'h01, 2, 0, TGT, 1'b0);
        run(8'h50, 8'h00, 2, 0, TGT, 1'b0);
        chk("observing after end", 16'h0000, 16'(obs_active));
        close_out();
    end
endmodule : testbench
